// ===== hdl/scc_pkg.sv
// Constants, field layouts and state codes of the serdes channel control.
// Assumes a single 125 MHz pclk domain and an APB register slave.
package scc_pkg;

    // ==================================================================
    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned POR_TIME_NS   = 1000;
    localparam int unsigned POR_CYCLES    =
        (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  POR_LAST      = 8'(POR_CYCLES - 1);

    // ==================================================================
    // Framing
    localparam int unsigned DATA_W        = 18;
    localparam int unsigned FRAME_W       = 20;
    localparam int unsigned BIT_RATE_MULT = 20;
    localparam logic [4:0]  FRAME_LAST    = 5'(FRAME_W - 1);
    localparam logic        START_BIT     = 1'b1;
    localparam logic        STOP_BIT      = 1'b0;
    localparam logic [17:0] ALIGN_PATTERN = 18'h1FE00;
    localparam logic [19:0] ALIGN_FRAME   =
        {START_BIT, ALIGN_PATTERN, STOP_BIT};
    localparam logic [2:0]  LOCK_FRAMES_LAST = 3'h3;
    localparam logic [4:0]  RXCLK_RISE    = 5'h04;
    localparam logic [4:0]  RXCLK_FALL    = 5'h0E;

    // ==================================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_RXDATA   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h14;

    // Control fields
    localparam int unsigned CTRL_POWER_ON = 0;
    localparam int unsigned CTRL_FAST_ALN = 1;
    localparam int unsigned CTRL_LOOPBACK = 2;
    localparam int unsigned CTRL_EMPHASIS = 3;
    localparam int unsigned CTRL_W        = 4;
    localparam logic [3:0]  CTRL_RESET    = 4'h1;

    // Interrupt events
    localparam int unsigned IRQ_LOCK_GAIN = 0;
    localparam int unsigned IRQ_LOCK_LOSS = 1;
    localparam int unsigned IRQ_RX_WORD   = 2;
    localparam int unsigned IRQ_W         = 3;
    localparam logic [2:0]  IRQ_EN_RESET  = 3'h0;

    // ==================================================================
    // Channel power state
    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_POR = 2'b01,
        PWR_RUN = 2'b10
    } scc_pwr_e;

endpackage

// ===== hdl/scc_rx_align.sv
// Receive word aligner and deserializer, one serial bit per pclk.
// Assumes the caller holds enable low through power-down and reset.
`timescale 1ns/1ns
`default_nettype none
module scc_rx_align
    import scc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        enable,
    input  wire logic        bit_in,
    output logic [17:0]      word_r,
    output logic             word_stb_r,
    output logic             locked_r,
    output logic             rx_clk_r
);

    // ==================================================================
    // Window and checks
    logic [19:0] wnd_r;
    logic [19:0] wnd_nxt;
    logic [4:0]  cnt_r;
    logic [2:0]  good_r;
    logic        frame_ok;
    logic        align_hit;

    assign wnd_nxt   = {wnd_r[18:0], bit_in};
    assign frame_ok  = (wnd_nxt[19] == START_BIT) &&
                       (wnd_nxt[0] == STOP_BIT);
    assign align_hit = (wnd_nxt == ALIGN_FRAME);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wnd_r <= 20'h00000;
        end else if (!enable) begin
            wnd_r <= 20'h00000;
        end else begin
            wnd_r <= wnd_nxt;
        end
    end

    // ==================================================================
    // Boundary search; a bad frame holds the counter so the check slides
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r      <= 5'h00;
            good_r     <= 3'h0;
            locked_r   <= 1'b0;
            word_r     <= 18'h00000;
            word_stb_r <= 1'b0;
        end else if (!enable) begin
            cnt_r      <= 5'h00;
            good_r     <= 3'h0;
            locked_r   <= 1'b0;
            word_stb_r <= 1'b0;
        end else if (align_hit) begin
            cnt_r      <= 5'h00;
            locked_r   <= 1'b1;
            good_r     <= LOCK_FRAMES_LAST;
            word_r     <= wnd_nxt[18:1];
            word_stb_r <= 1'b1;
        end else if (cnt_r == FRAME_LAST) begin
            if (frame_ok) begin
                cnt_r      <= 5'h00;
                word_r     <= wnd_nxt[18:1];
                word_stb_r <= locked_r;
                if (good_r == LOCK_FRAMES_LAST) begin
                    locked_r <= 1'b1;
                end else begin
                    good_r <= good_r + 3'h1;
                end
            end else begin
                good_r     <= 3'h0;
                locked_r   <= 1'b0;
                word_stb_r <= 1'b0;
            end
        end else begin
            cnt_r      <= cnt_r + 5'h01;
            word_stb_r <= 1'b0;
        end
    end

    // ==================================================================
    // Recovered clock: word period divided down, rising a quarter into the word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_clk_r <= 1'b0;
        end else begin
            rx_clk_r <= enable && locked_r &&
                        (cnt_r >= RXCLK_RISE) &&
                        (cnt_r < RXCLK_FALL);
        end
    end

endmodule
`default_nettype wire

// ===== hdl/scc_channel.sv
// Serdes channel control: framing, serializer, loopback, power and APB.
// Assumes the protocol device toggles tx_reference_clock every 10 pclk.
// Function
// - Serial NRZ at twenty bits per reference period
// - Loopback select floats serial outputs
// - Serial outputs floated during power-on reset
// - Power-on low puts channel in power-down
// - Power-on high passes through reset first
// - Parallel word registered on reference rising edge
// - Fast align substitutes fixed pattern before framing
// - Framed align pattern gives immediate word boundary
// - Loopback routes serial transmit into receiver
// - Aligned low only after start/stop located
// - Emphasis boosts first bit of each run
// - Receiver strips framing, presents 18 data bits
// - Receive clock is bit clock over twenty
// - Receive word valid at receive clock rise
// - Receive clock held low in power-on reset
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module scc_channel
    import scc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_reference_clock,
    input  wire logic [17:0] tx_parallel_word,
    output logic             serial_tx_out_pos,
    output logic             serial_tx_out_neg,
    output logic             serial_tx_oe_n,
    output logic             serial_tx_emphasis,
    input  wire logic        serial_rx_in_pos,
    input  wire logic        serial_rx_in_neg,
    output logic [17:0]      rx_parallel_word,
    output logic             rx_word_oe_n,
    output logic             rx_recovered_clock,
    output logic             rx_aligned_n,
    output logic             irq
);

    // ==================================================================
    // Declarations
    logic [3:0]  ctrl_r;
    logic [2:0]  irq_stat_r;
    logic [2:0]  irq_en_r;
    logic [31:0] prdata_r;
    scc_pwr_e    pwr_r;
    logic [7:0]  por_cnt_r;
    logic        ref_d_r;
    logic [17:0] tx_hold_r;
    logic [4:0]  tx_cnt_r;
    logic [19:0] tx_sh_r;
    logic [19:0] tx_frame;
    logic        tx_bit_nxt;
    logic        tx_neg_r;
    logic        tx_emph_r;
    logic        running;
    logic        rx_bit;
    logic [17:0] rx_word;
    logic        rx_stb;
    logic        rx_locked;
    logic        rx_clk;
    logic        locked_d_r;
    logic [2:0]  irq_ev;
    logic        wr_en;
    logic        addr_ok;

    assign running = (pwr_r == PWR_RUN);

    // ==================================================================
    // APB slave, zero wait states
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign addr_ok = (paddr == ADDR_CTRL)     || (paddr == ADDR_STATUS) ||
                     (paddr == ADDR_RXDATA)   || (paddr == ADDR_IRQ_STAT) ||
                     (paddr == ADDR_IRQ_CLR)  || (paddr == ADDR_IRQ_EN);
    assign pslverr = psel && penable && !addr_ok;
    assign prdata  = prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= CTRL_RESET;
            irq_en_r <= IRQ_EN_RESET;
        end else if (wr_en) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_r <= pwdata[CTRL_W-1:0];
            end
            if (paddr == ADDR_IRQ_EN) begin
                irq_en_r <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // Read data latched in the setup phase, so it is stable in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (psel && !penable) begin
            case (paddr)
                ADDR_CTRL:     prdata_r <= {28'h0000000, ctrl_r};
                ADDR_STATUS:   prdata_r <= {29'h00000000, rx_locked,
                                            pwr_r};
                ADDR_RXDATA:   prdata_r <= {14'h0000, rx_parallel_word};
                ADDR_IRQ_STAT: prdata_r <= {29'h00000000, irq_stat_r};
                ADDR_IRQ_EN:   prdata_r <= {29'h00000000, irq_en_r};
                default:       prdata_r <= 32'h00000000;
            endcase
        end
    end

    // ==================================================================
    // Interrupts; a new event beats a clear in the same cycle
    assign irq_ev = {rx_stb, locked_d_r && !rx_locked,
                     !locked_d_r && rx_locked};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_d_r <= 1'b0;
            irq_stat_r <= 3'h0;
        end else begin
            locked_d_r <= rx_locked;
            if (wr_en && (paddr == ADDR_IRQ_CLR)) begin
                irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_stat_r <= irq_stat_r | irq_ev;
            end
        end
    end

    assign irq = |(irq_stat_r & irq_en_r);

    // ==================================================================
    // Power sequencing; presetn itself counts as a power-on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_r     <= PWR_POR;
            por_cnt_r <= 8'h00;
        end else if (!ctrl_r[CTRL_POWER_ON]) begin
            pwr_r     <= PWR_OFF;
            por_cnt_r <= 8'h00;
        end else begin
            case (pwr_r)
                PWR_OFF: begin
                    pwr_r     <= PWR_POR;
                    por_cnt_r <= 8'h00;
                end
                PWR_POR: begin
                    if (por_cnt_r == POR_LAST) begin
                        pwr_r <= PWR_RUN;
                    end else begin
                        por_cnt_r <= por_cnt_r + 8'h01;
                    end
                end
                PWR_RUN: pwr_r <= PWR_RUN;
                default: pwr_r <= PWR_POR;
            endcase
        end
    end

    // ==================================================================
    // Transmit word capture on the reference rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_d_r   <= 1'b0;
            tx_hold_r <= 18'h00000;
        end else begin
            ref_d_r <= tx_reference_clock;
            if (tx_reference_clock && !ref_d_r) begin
                tx_hold_r <= tx_parallel_word;
            end
        end
    end

    // ==================================================================
    // Serializer: one bit per pclk, twenty bits per frame
    assign tx_frame = {START_BIT,
                       ctrl_r[CTRL_FAST_ALN] ? ALIGN_PATTERN : tx_hold_r,
                       STOP_BIT};
    assign tx_bit_nxt = (tx_cnt_r == 5'h00) ? tx_frame[19] : tx_sh_r[18];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt_r  <= 5'h00;
            tx_sh_r   <= 20'h00000;
            tx_neg_r  <= 1'b1;
            tx_emph_r <= 1'b0;
        end else if (!running) begin
            tx_cnt_r  <= 5'h00;
            tx_sh_r   <= 20'h00000;
            tx_neg_r  <= 1'b1;
            tx_emph_r <= 1'b0;
        end else begin
            if (tx_cnt_r == 5'h00) begin
                tx_sh_r <= tx_frame;
            end else begin
                tx_sh_r <= {tx_sh_r[18:0], 1'b0};
            end
            if (tx_cnt_r == FRAME_LAST) begin
                tx_cnt_r <= 5'h00;
            end else begin
                tx_cnt_r <= tx_cnt_r + 5'h01;
            end
            tx_neg_r  <= !tx_bit_nxt;
            tx_emph_r <= ctrl_r[CTRL_EMPHASIS] &&
                         (tx_bit_nxt != tx_sh_r[19]);
        end
    end

    assign serial_tx_out_pos  = tx_sh_r[19];
    assign serial_tx_out_neg  = tx_neg_r;
    assign serial_tx_emphasis = tx_emph_r;
    // Floated in loopback, power-down and power-on reset
    assign serial_tx_oe_n     = ctrl_r[CTRL_LOOPBACK] || !running;

    // ==================================================================
    // Receive path; equal line levels read as a zero
    assign rx_bit = ctrl_r[CTRL_LOOPBACK] ? tx_sh_r[19] :
                    (serial_rx_in_pos && !serial_rx_in_neg);

    scc_rx_align u_align (
        .clk        (pclk),
        .rst_n      (presetn),
        .enable     (running),
        .bit_in     (rx_bit),
        .word_r     (rx_word),
        .word_stb_r (rx_stb),
        .locked_r   (rx_locked),
        .rx_clk_r   (rx_clk)
    );

    assign rx_parallel_word   = rx_word;
    assign rx_word_oe_n       = !running;
    assign rx_recovered_clock = rx_clk;
    assign rx_aligned_n       = !rx_locked;

endmodule
`default_nettype wire

// ===== test/scc_channel_props.sv
// Port-level checker for the serdes channel control.
// Assumes one pclk domain; bound onto every scc_channel.
`timescale 1ns/1ns
`default_nettype none
module scc_channel_props
    import scc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        serial_tx_out_pos,
    input wire logic        serial_tx_out_neg,
    input wire logic        serial_tx_oe_n,
    input wire logic        serial_tx_emphasis,
    input wire logic [17:0] rx_parallel_word,
    input wire logic        rx_word_oe_n,
    input wire logic        rx_recovered_clock,
    input wire logic        rx_aligned_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========================================
    // Serial side
    chk_pair_diff: assert property (
        !serial_tx_oe_n |-> serial_tx_out_neg != serial_tx_out_pos)
        else $error("serial pair not complementary");
    chk_float_idle: assert property (
        rx_word_oe_n |-> serial_tx_oe_n)
        else $error("serial outputs driven while idle");
    chk_emph_first: assert property (
        serial_tx_emphasis |-> serial_tx_out_pos != $past(serial_tx_out_pos))
        else $error("emphasis away from run start");
    // ========================================
    // Receive side
    chk_align_idle: assert property (
        rx_word_oe_n && $past(rx_word_oe_n) |-> rx_aligned_n)
        else $error("aligned while powered down");
    chk_rxclk_por: assert property (
        rx_word_oe_n && $past(rx_word_oe_n) |-> !rx_recovered_clock)
        else $error("receive clock high while idle");
    chk_lock_run: assert property (
        $fell(rx_aligned_n) |-> !rx_word_oe_n)
        else $error("lock outside run state");
    chk_word_stable: assert property (
        $rose(rx_recovered_clock) && !rx_aligned_n
            |-> $stable(rx_parallel_word))
        else $error("rx word moved at clock rise");
    // High for the eight cycles after the rise, unless lock drops
    chk_rxclk_high: assert property (
        $rose(rx_recovered_clock) && !rx_aligned_n
            |=> (rx_recovered_clock || rx_aligned_n)[*8])
        else $error("receive clock high phase short");
    // ========================================
    // Register bus
    chk_apb_err: assert property (
        psel && penable && paddr[1:0] == 2'h0
            |-> pready && (pslverr == (paddr > ADDR_IRQ_EN)))
        else $error("bus response wrong");
endmodule

bind scc_channel scc_channel_props u_props (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr),
    .serial_tx_out_pos(serial_tx_out_pos),
    .serial_tx_out_neg(serial_tx_out_neg),
    .serial_tx_oe_n(serial_tx_oe_n),
    .serial_tx_emphasis(serial_tx_emphasis),
    .rx_parallel_word(rx_parallel_word), .rx_word_oe_n(rx_word_oe_n),
    .rx_recovered_clock(rx_recovered_clock), .rx_aligned_n(rx_aligned_n)
);
`default_nettype wire

// ===== test/scc_proto_model.sv
// Protocol device model: reference clock, transmit words, rx capture.
// Assumes pclk at 125 MHz; reference period is 20 pclk.
`timescale 1ns/1ns
`default_nettype none
module scc_proto_model (
    input  wire logic        pclk,
    input  wire logic [17:0] word_in,
    input  wire logic [17:0] rx_word,
    input  wire logic        rx_clk,
    input  wire logic        rx_aligned_n,
    output logic             ref_clk,
    output logic [17:0]      tx_word,
    output logic [17:0]      last_rx,
    output int unsigned      rx_count
);
    logic [3:0] div_r;
    logic       rx_clk_r;
    initial begin
        div_r = 4'h0;
        rx_clk_r = 1'b0;
        ref_clk = 1'b0;
        tx_word = 18'h0;
        last_rx = 18'h0;
        rx_count = 0;
    end
    // Runs through reset too, never gated
    always @(posedge pclk) begin
        div_r <= (div_r == 4'h9) ? 4'h0 : div_r + 4'h1;
        if (div_r == 4'h9) begin
            ref_clk <= ~ref_clk;
            // Word moves half a period before the rise
            if (ref_clk) tx_word <= word_in;
        end
    end
    // Capture on the receive clock rise only when aligned
    always @(posedge pclk) begin
        rx_clk_r <= rx_clk;
        if (rx_clk && !rx_clk_r && !rx_aligned_n) begin
            last_rx <= rx_word;
            rx_count <= rx_count + 1;
        end
    end
endmodule
`default_nettype wire

// ===== test/scc_channel_tb.sv
// Self-checking bench for the serdes channel control.
// Assumes the proto model and a bound checker; own cable loops tx to rx.
`timescale 1ns/1ns
`default_nettype none
module scc_channel_tb;
    import scc_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic        rx_pos = 1'b0;
    logic        rx_neg = 1'b1;
    logic [17:0] m_word = 18'h0;
    logic [31:0] prdata, rdat;
    logic        pready, pslverr, perr, ref_clk, tx_pos, tx_neg;
    logic        tx_oe_n, emph, rx_oe_n, rx_clk, rx_aligned_n, irq;
    logic [17:0] tx_word, rx_word, last_rx;
    int unsigned rx_count;
    int          err_total = 0;
    int          n_tests = 0;
    always #4 pclk = ~pclk;
    scc_channel dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_reference_clock(ref_clk), .tx_parallel_word(tx_word),
        .serial_tx_out_pos(tx_pos), .serial_tx_out_neg(tx_neg),
        .serial_tx_oe_n(tx_oe_n), .serial_tx_emphasis(emph),
        .serial_rx_in_pos(rx_pos), .serial_rx_in_neg(rx_neg),
        .rx_parallel_word(rx_word), .rx_word_oe_n(rx_oe_n),
        .rx_recovered_clock(rx_clk), .rx_aligned_n(rx_aligned_n),
        .irq(irq));
    scc_proto_model m (.pclk(pclk), .word_in(m_word), .rx_word(rx_word),
        .rx_clk(rx_clk), .rx_aligned_n(rx_aligned_n), .ref_clk(ref_clk),
        .tx_word(tx_word), .last_rx(last_rx), .rx_count(rx_count));
    // Cable; a floated line toggles so no stale value survives
    always @(posedge pclk) begin
        rx_pos <= tx_oe_n ? ~rx_pos : tx_pos;
        rx_neg <= tx_oe_n ? ~rx_neg : tx_neg;
    end
    // ========================================
    // Shared tasks
    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %b, seen %b", nm, e, g);
        end
    endtask
    task automatic chkw(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chkw($sformatf("reg %h", a), e, rdat);
    endtask
    task automatic wait_state(input logic [1:0] s);
        int n;
        n = 0;
        do begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end while (rdat[1:0] !== s && n < 200);
        chkw("power state", {30'h0, s}, {30'h0, rdat[1:0]});
    endtask
    task automatic wait_words(input int k);
        int unsigned c;
        c = rx_count + k;
        repeat (30 * k) if (rx_count < c) @(posedge pclk);
    endtask
    // Bounded wait for a lock level, judged once settled
    task automatic wait_aln(input logic v, input int lim);
        int n;
        n = 0;
        while (rx_aligned_n !== v && n < lim) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk1("aligned_n", v, rx_aligned_n);
    endtask
    // Lock loss on the path change, then fast relock
    task automatic relock(input logic [31:0] c);
        apb(1'b1, ADDR_CTRL, c | 32'h2);
        wait_aln(1'b1, 40);
        wait_aln(1'b0, 70);
        wait_words(2);
        chkw("align word", 32'h1FE00, {14'h0, last_rx});
        apb(1'b1, ADDR_CTRL, c);
    endtask
    task automatic send(input logic [17:0] w);
        m_word <= w;
        wait_words(5);
        chkw("rx word", {14'h0, w}, {14'h0, last_rx});
        rd(ADDR_RXDATA, {14'h0, w});
    endtask
    task automatic emph_count(input logic [31:0] c, output int k);
        apb(1'b1, ADDR_CTRL, c);
        k = 0;
        repeat (40) begin
            @(posedge pclk);
            #1;
            if (emph === 1'b1) k++;
        end
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset();
        chk1("tx oe_n", 1'b1, tx_oe_n);
        chk1("rx clock", 1'b0, rx_clk);
        rd(ADDR_STATUS, 32'h1);
        rd(ADDR_CTRL, 32'h1);
        rd(ADDR_IRQ_EN, 32'h0);
        chk1("aligned_n", 1'b1, rx_aligned_n);
        wait_state(2'h2);
        chk1("tx oe_n", 1'b0, tx_oe_n);
        // External path must hold lock before the loopback switch
        wait_aln(1'b0, 200);
        apb(1'b0, 8'h40, 32'h0);
        chk1("pslverr", 1'b1, perr);
        chkw("unmapped", 32'h0, rdat);
        apb(1'b1, ADDR_STATUS, 32'hFF);
        rd(ADDR_STATUS, 32'h6);
        rd(ADDR_IRQ_CLR, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_link();
        apb(1'b1, ADDR_IRQ_EN, 32'h1);
        relock(32'h5);
        chk1("tx oe_n", 1'b1, tx_oe_n);
        send(18'h2A5C3);
        chk1("irq", 1'b1, irq);
        rd(ADDR_IRQ_STAT, 32'h7);
        apb(1'b1, ADDR_IRQ_EN, 32'h0);
        chk1("irq masked", 1'b0, irq);
        apb(1'b1, ADDR_IRQ_CLR, 32'h1);
        apb(1'b1, ADDR_IRQ_EN, 32'h1);
        chk1("irq cleared", 1'b0, irq);
        relock(32'h1);
        chk1("tx oe_n", 1'b0, tx_oe_n);
        send(18'h15A3C);
        $display("t_link done");
    endtask
    task automatic t_power();
        int k;
        emph_count(32'h9, k);
        chk1("emphasis on", 1'b1, k > 0);
        emph_count(32'h1, k);
        chk1("emphasis off", 1'b0, k > 0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        wait_state(2'h0);
        chk1("tx oe_n", 1'b1, tx_oe_n);
        chk1("aligned_n", 1'b1, rx_aligned_n);
        apb(1'b1, ADDR_CTRL, 32'h1);
        rd(ADDR_STATUS, 32'h1);
        chk1("tx oe_n", 1'b1, tx_oe_n);
        chk1("rx clock", 1'b0, rx_clk);
        wait_state(2'h2);
        $display("t_power done");
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        t_reset();
        t_link();
        t_power();
        conclude();
    end
    // Whole run is about a thousand cycles
    initial begin
        #100000;
        err_total++;
        conclude();
    end
endmodule
`default_nettype wire
